// File: hw/e1ev_top.sv
// Event flags, masks and interrupt of the E1 receive framer
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module e1ev_top
#(
    parameter int WIN_CYC = e1ev_pkg::WINDOW_CYC,
    parameter int POS_W = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Alignment states from the framer
    input wire logic interwork_state_i,
    input wire logic sig_mf_loss_state_i,
    input wire logic crc_mf_loss_state_i,
    input wire logic offline_loss_state_i,
    input wire logic frame_loss_state_i,
    // Line bit stream and positions
    input wire logic line_bit_en_i,
    input wire logic line_bit_i,
    input wire logic sig_mf_first_i,
    input wire logic crc_submf_first_i,
    input wire logic crc_mf_first_i,
    input wire logic crc_cbit_i,
    // Extracted alignment words
    input wire logic sig_mf_word_vld_i,
    input wire logic [3:0] sig_mf_word_i,
    input wire logic crc_mf_word_vld_i,
    input wire logic [5:0] crc_mf_word_i,
    input wire logic fas_word_vld_i,
    input wire logic [6:0] fas_word_i,
    input wire logic nfas_vld_i,
    input wire logic nfas_bit_i,
    input wire logic align_found_i,
    input wire logic [POS_W-1:0] align_pos_i,
    // Interrupt
    output logic irq_n_o
);
    localparam int WC_W = $clog2(WIN_CYC + 1);

    generate
        if (WIN_CYC < 1024 || POS_W < 1)
        begin : g_bad_param
            $error("window must hold the excess limit; POS_W >= 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic ack_r;
    logic wr_w;
    logic [7:0] wd_w;
    logic [7:0] idx_w;
    logic [7:0] en0_r;
    logic [7:0] en1_r;
    logic [7:0] mode_r;
    logic [7:0] flags0_r;
    logic [7:0] flags1_r;
    logic [7:0] set0_w;
    logic [7:0] set1_w;
    logic [4:0] st_prev_r;
    logic [7:0] ferr_cnt_r;
    logic [7:0] rd_w;

    function automatic logic hit(input logic [7:0] idx,
        input logic [7:0] reg_idx);
        hit = idx == reg_idx;
    endfunction

    // Hardware set wins over a clear in the same cycle
    function automatic logic [7:0] w1c(input logic [7:0] old,
        input logic [7:0] set, input logic [7:0] clr);
        w1c = (old & ~clr) | set;
    endfunction

    function automatic logic [2:0] ones7(input logic [6:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int k = 0; k < 7; k++)
            n = n + {2'h0, v[k]};
        ones7 = n;
    endfunction

    assign idx_w = wb_adr_i[9:2];
    // Writes take effect on the edge that ends the ack cycle
    assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
    assign wd_w = wb_dat_i[7:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    always_comb
    begin
        rd_w = 8'h00;
        case (idx_w)
            e1ev_pkg::IDX_FERR_CNT: rd_w = ferr_cnt_r;
            e1ev_pkg::IDX_MODE: rd_w = mode_r;
            e1ev_pkg::IDX_STATUS: rd_w = {3'h0, st_prev_r};
            e1ev_pkg::IDX_EN0: rd_w = en0_r;
            e1ev_pkg::IDX_EN1: rd_w = en1_r;
            e1ev_pkg::IDX_FLAG0: rd_w = flags0_r;
            e1ev_pkg::IDX_FLAG1: rd_w = flags1_r;
            default: rd_w = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h00000000;
        else
            wb_dat_o <= {24'h000000, rd_w};
    end

    assign wb_ack_o = ack_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en0_r <= e1ev_pkg::RST_EN;
            en1_r <= e1ev_pkg::RST_EN;
            mode_r <= e1ev_pkg::RST_MODE;
        end
        else if (wr_w)
        begin
            if (hit(idx_w, e1ev_pkg::IDX_EN0))
                en0_r <= {2'h0, wd_w[5:0]};
            if (hit(idx_w, e1ev_pkg::IDX_EN1))
                en1_r <= wd_w;
            if (hit(idx_w, e1ev_pkg::IDX_MODE))
                mode_r <= {3'h0, wd_w[4:3], 3'h0};
        end
    end

    // ------------------------------------------------------------
    // Alignment state changes
    // ------------------------------------------------------------
    logic [4:0] st_now_w;

    assign st_now_w = {interwork_state_i, sig_mf_loss_state_i,
        crc_mf_loss_state_i, offline_loss_state_i, frame_loss_state_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_prev_r <= e1ev_pkg::RST_STATUS;
        else
            st_prev_r <= st_now_w;
    end

    // ------------------------------------------------------------
    // Excessive CRC-4 errors in fixed one-second windows
    // ------------------------------------------------------------
    e1ev_crc_if crc_if();
    logic [WC_W-1:0] win_r;
    logic [9:0] crc_cnt_r;
    logic win_end_w;
    logic excess_w;

    assign crc_if.bit_en = line_bit_en_i;
    assign crc_if.rx_bit = line_bit_i;
    assign crc_if.submf_first = crc_submf_first_i;
    assign crc_if.cbit = crc_cbit_i;
    assign crc_if.sync = !crc_mf_loss_state_i;

    e1ev_crc4_chk u_crc
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lnk(crc_if)
    );

    assign win_end_w = win_r == WC_W'(WIN_CYC - 1);
    // Fires once, on the error that brings the count to the limit
    assign excess_w = crc_if.err && !crc_mf_loss_state_i
        && crc_cnt_r == e1ev_pkg::EXCESS_LIMIT - 10'h001 && !win_end_w;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || win_end_w)
            win_r <= '0;
        else
            win_r <= win_r + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || crc_mf_loss_state_i)
            crc_cnt_r <= 10'h000;
        else if (win_end_w)
            crc_cnt_r <= {9'h000, crc_if.err};
        else if (crc_if.err && crc_cnt_r != e1ev_pkg::EXCESS_LIMIT)
            crc_cnt_r <= crc_cnt_r + 10'h001;
    end

    // ------------------------------------------------------------
    // Frame word errors and alignment position
    // ------------------------------------------------------------
    logic [2:0] fas_bits_w;
    logic fas_bad_w;
    logic nfas_bad_w;
    logic [3:0] fevents_w;
    logic [POS_W-1:0] pos_r;
    logic have_pos_r;
    logic moved_w;

    assign fas_bits_w = ones7(fas_word_i ^ e1ev_pkg::FAS_PATTERN);
    assign fas_bad_w = fas_word_vld_i && !frame_loss_state_i
        && fas_bits_w != 3'h0;
    assign nfas_bad_w = nfas_vld_i && !frame_loss_state_i && !nfas_bit_i
        && mode_r[e1ev_pkg::B_ODD_SEL];

    // Bit mode counts every wrong bit, word mode one per word
    always_comb
    begin
        fevents_w = {3'h0, nfas_bad_w};
        if (fas_bad_w)
        begin
            if (mode_r[e1ev_pkg::B_WHOLE_SEL])
                fevents_w = fevents_w + 4'h1;
            else
                fevents_w = fevents_w + {1'b0, fas_bits_w};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ferr_cnt_r <= 8'h00;
        else
            ferr_cnt_r <= ferr_cnt_r + {4'h0, fevents_w};
    end

    assign moved_w = align_found_i && have_pos_r && align_pos_i != pos_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pos_r <= '0;
            have_pos_r <= 1'b0;
        end
        else if (align_found_i)
        begin
            pos_r <= align_pos_i;
            have_pos_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags and interrupt
    // ------------------------------------------------------------
    logic sig_sync_w;
    logic crc_sync_w;

    assign sig_sync_w = !sig_mf_loss_state_i;
    assign crc_sync_w = !crc_mf_loss_state_i;

    always_comb
    begin
        set0_w = 8'h00;
        set0_w[e1ev_pkg::B_EXCESS] = excess_w;
        set0_w[4:0] = st_now_w ^ st_prev_r;
        set1_w = 8'h00;
        set1_w[e1ev_pkg::B_SMF_START] = line_bit_en_i && sig_mf_first_i
            && sig_sync_w;
        set1_w[e1ev_pkg::B_SUBMF_START] = line_bit_en_i
            && crc_submf_first_i && crc_sync_w;
        set1_w[e1ev_pkg::B_SMF_PAT] = sig_mf_word_vld_i && sig_sync_w
            && sig_mf_word_i != e1ev_pkg::SMF_PATTERN;
        set1_w[e1ev_pkg::B_CMF_START] = line_bit_en_i && crc_mf_first_i
            && crc_sync_w;
        set1_w[e1ev_pkg::B_CMF_PAT] = crc_mf_word_vld_i && crc_sync_w
            && crc_mf_word_i != e1ev_pkg::CMF_PATTERN;
        set1_w[e1ev_pkg::B_CRC4] = crc_if.err;
        set1_w[e1ev_pkg::B_FWORD] = fas_bad_w || nfas_bad_w;
        set1_w[e1ev_pkg::B_ALIGN] = moved_w;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags0_r <= e1ev_pkg::RST_FLAG;
            flags1_r <= e1ev_pkg::RST_FLAG;
        end
        else
        begin
            flags0_r <= w1c(flags0_r, set0_w,
                (wr_w && hit(idx_w, e1ev_pkg::IDX_FLAG0)) ? wd_w : 8'h00);
            flags1_r <= w1c(flags1_r, set1_w,
                (wr_w && hit(idx_w, e1ev_pkg::IDX_FLAG1)) ? wd_w : 8'h00);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_n_o <= 1'b1;
        else
            irq_n_o <= !(|(flags0_r & en0_r) || |(flags1_r & en1_r));
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_irq_level;
        !irq_n_o == $past(|(flags0_r & en0_r) || |(flags1_r & en1_r));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output does not follow enabled flags");

    property p_mask;
        (en0_r == 8'h00 && en1_r == 8'h00) |=> irq_n_o;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked flag drove the interrupt");

    property p_change;
        (frame_loss_state_i != st_prev_r[0])
            |=> flags0_r[e1ev_pkg::B_FRM_LOSS];
    endproperty
    a_change: assert property (p_change)
        else $error("frame loss toggle did not set its flag");

    property p_w1c;
        (wr_w && hit(idx_w, e1ev_pkg::IDX_FLAG1) && set1_w == 8'h00)
            |=> flags1_r == ($past(flags1_r) & ~$past(wd_w));
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear exactly its flags");

    property p_stick;
        !(wr_w && hit(idx_w, e1ev_pkg::IDX_FLAG0))
            |=> (flags0_r & $past(flags0_r)) == $past(flags0_r);
    endproperty
    a_stick: assert property (p_stick)
        else $error("flag cleared without a write");

    property p_smf_start;
        (line_bit_en_i && sig_mf_first_i && !sig_mf_loss_state_i)
            |=> flags1_r[e1ev_pkg::B_SMF_START];
    endproperty
    a_smf_start: assert property (p_smf_start)
        else $error("signaling multiframe start not flagged");

    property p_cmf_quiet;
        (crc_mf_loss_state_i && !flags1_r[e1ev_pkg::B_CMF_START])
            |=> !flags1_r[e1ev_pkg::B_CMF_START];
    endproperty
    a_cmf_quiet: assert property (p_cmf_quiet)
        else $error("crc multiframe start flagged while out of alignment");

    property p_smf_pat;
        (sig_mf_word_vld_i && !sig_mf_loss_state_i && sig_mf_word_i != 4'h0)
            |=> flags1_r[e1ev_pkg::B_SMF_PAT];
    endproperty
    a_smf_pat: assert property (p_smf_pat)
        else $error("signaling alignment error not flagged");

    property p_excess;
        excess_w |=> flags0_r[e1ev_pkg::B_EXCESS] && crc_cnt_r == 10'h393;
    endproperty
    a_excess: assert property (p_excess)
        else $error("excess crc-4 flag missing at the limit");

    property p_excess_hold;
        crc_mf_loss_state_i |=> crc_cnt_r == 10'h000;
    endproperty
    a_excess_hold: assert property (p_excess_hold)
        else $error("crc-4 error count ran while out of alignment");

    property p_word_cnt;
        (fas_word_vld_i && !frame_loss_state_i && !nfas_vld_i
            && mode_r[e1ev_pkg::B_WHOLE_SEL] && fas_bits_w != 3'h0)
            |=> ferr_cnt_r == 8'($past(ferr_cnt_r) + 8'h01);
    endproperty
    a_word_cnt: assert property (p_word_cnt)
        else $error("word mode did not count one event per word");

    property p_move;
        moved_w |=> flags1_r[e1ev_pkg::B_ALIGN];
    endproperty
    a_move: assert property (p_move)
        else $error("alignment move not flagged");

    c_irq: cover property (!irq_n_o);
    c_excess: cover property (excess_w);
    c_crc_err: cover property (crc_if.err);
    c_move: cover property (moved_w);
endmodule
`default_nettype wire

// File: inc/e1ev_pkg.sv
// Constants, field layout and types of the E1 receive framer event block
package e1ev_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FERR_CNT = 8'h4C;
    localparam logic [7:0] IDX_MODE = 8'h4E;
    localparam logic [7:0] IDX_STATUS = 8'h4F;
    localparam logic [7:0] IDX_EN0 = 8'h50;
    localparam logic [7:0] IDX_EN1 = 8'h51;
    localparam logic [7:0] IDX_FLAG0 = 8'h52;
    localparam logic [7:0] IDX_FLAG1 = 8'h53;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [4:0] RST_STATUS = 5'h0D;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_EXCESS = 5;
    localparam int B_IWK = 4;
    localparam int B_SMF_LOSS = 3;
    localparam int B_CMF_LOSS = 2;
    localparam int B_OFF_LOSS = 1;
    localparam int B_FRM_LOSS = 0;
    localparam int B_SMF_START = 7;
    localparam int B_SUBMF_START = 6;
    localparam int B_SMF_PAT = 5;
    localparam int B_CMF_START = 4;
    localparam int B_CMF_PAT = 3;
    localparam int B_CRC4 = 2;
    localparam int B_FWORD = 1;
    localparam int B_ALIGN = 0;
    localparam int B_ODD_SEL = 4;
    localparam int B_WHOLE_SEL = 3;
    // ------------------------------------------------------------
    // Patterns, limits and timing
    // ------------------------------------------------------------
    localparam logic [3:0] SMF_PATTERN = 4'h0;
    localparam logic [5:0] CMF_PATTERN = 6'h0B;
    localparam logic [6:0] FAS_PATTERN = 7'h1B;
    localparam logic [9:0] EXCESS_LIMIT = 10'h393;
    localparam int CLK_HZ = 20000000;
    localparam int WINDOW_S = 1;
    localparam int WINDOW_CYC = WINDOW_S * CLK_HZ;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CK_WAIT, CK_FIRST, CK_RUN} e1ev_ck_t;
endpackage

// File: inc/e1ev_crc_if.sv
// Line stream from the event block to its CRC-4 checker
`timescale 1ns/100ps
`default_nettype none
interface e1ev_crc_if;
    logic bit_en;
    logic rx_bit;
    logic submf_first;
    logic cbit;
    logic sync;
    logic err;
    modport chk (input bit_en, rx_bit, submf_first, cbit, sync,
        output err);
    modport src (output bit_en, rx_bit, submf_first, cbit, sync,
        input err);
endinterface
`default_nettype wire

// File: hw/e1ev_crc4_chk.sv
// CRC-4 checker over received sub-multiframes
`timescale 1ns/100ps
`default_nettype none
module e1ev_crc4_chk
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Line stream
    e1ev_crc_if.chk lnk
);
    e1ev_pkg::e1ev_ck_t state_r;
    logic [3:0] crc_r;
    logic [3:0] held_r;
    logic [3:0] rx_c_r;
    logic err_r;
    logic edge_w;
    logic din_w;

    // C bits enter the remainder as zero
    function automatic logic [3:0] crc_step(input logic [3:0] c,
        input logic d);
        logic fb;
        fb = d ^ c[3];
        crc_step = {c[2], c[1], c[0] ^ fb, fb};
    endfunction

    assign edge_w = lnk.bit_en & lnk.submf_first;
    assign din_w = lnk.cbit ? 1'b0 : lnk.rx_bit;

    // ------------------------------------------------------------
    // Lock sequence: two boundaries before the first comparison
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !lnk.sync)
            state_r <= e1ev_pkg::CK_WAIT;
        else if (edge_w)
        begin
            case (state_r)
                e1ev_pkg::CK_WAIT: state_r <= e1ev_pkg::CK_FIRST;
                e1ev_pkg::CK_FIRST: state_r <= e1ev_pkg::CK_RUN;
                e1ev_pkg::CK_RUN: state_r <= e1ev_pkg::CK_RUN;
                default: state_r <= e1ev_pkg::CK_WAIT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Remainder and received check bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            crc_r <= 4'h0;
            held_r <= 4'h0;
            rx_c_r <= 4'h0;
        end
        else if (lnk.bit_en)
        begin
            if (lnk.submf_first)
            begin
                held_r <= crc_r;
                crc_r <= crc_step(4'h0, din_w);
                rx_c_r <= lnk.cbit ? {3'h0, lnk.rx_bit} : 4'h0;
            end
            else
            begin
                crc_r <= crc_step(crc_r, din_w);
                if (lnk.cbit)
                    rx_c_r <= {rx_c_r[2:0], lnk.rx_bit};
            end
        end
    end

    // Check bits of one sub-multiframe ride in the next one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            err_r <= 1'b0;
        else
            err_r <= edge_w && lnk.sync && state_r == e1ev_pkg::CK_RUN
                && held_r != rx_c_r;
    end

    assign lnk.err = err_r;

    property p_crc_cmp;
        @(posedge clk_i) disable iff (rst_i)
        (edge_w && lnk.sync && state_r == e1ev_pkg::CK_RUN
            && held_r != rx_c_r) |=> err_r;
    endproperty
    a_crc_cmp: assert property (p_crc_cmp)
        else $error("crc-4 mismatch gave no error event");
endmodule
`default_nettype wire

// File: bench/e1ev_line_mdl.sv
// Line-side model that sends CRC sub-multiframes of the E1 stream
`timescale 1ns/100ps
`default_nettype none
module e1ev_line_mdl
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Command
    input wire logic go_i,
    input wire logic [1:0] mf_sel_i,
    input wire logic cval_i,
    input wire logic [11:0] nsub_i,
    output logic busy_o,
    // Line stream
    output logic bit_en_o,
    output logic bit_o,
    output logic sig_mf_first_o,
    output logic crc_submf_first_o,
    output logic crc_mf_first_o,
    output logic cbit_o
);
    logic [11:0] left_r;
    logic [2:0] ph_r;
    logic first_r;
    logic tog_r;
    // Each sub-multiframe: one zero data bit, then four C bits
    always_ff @(posedge clk_i)
    begin
        tog_r <= rst_i ? 1'b0 : ~tog_r;
        if (rst_i)
            left_r <= 12'h000;
        else if (go_i)
        begin
            left_r <= nsub_i;
            ph_r <= 3'h0;
            first_r <= 1'b1;
        end
        else if (busy_o)
        begin
            ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
            if (ph_r == 3'h4)
            begin
                left_r <= left_r - 12'h001;
                first_r <= 1'b0;
            end
        end
    end
    assign busy_o = (left_r != 12'h000);
    assign bit_en_o = busy_o;
    assign cbit_o = busy_o && (ph_r != 3'h0);
    assign crc_submf_first_o = busy_o && (ph_r == 3'h0);
    assign sig_mf_first_o = crc_submf_first_o && first_r && mf_sel_i[1];
    assign crc_mf_first_o = crc_submf_first_o && first_r && mf_sel_i[0];
    // Zero data gives remainder 0, so C bits of one are all wrong; idle
    // line keeps toggling so a stale bit is never taken for data
    assign bit_o = busy_o ? (cbit_o && cval_i) : tog_r;
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the E1 framer event block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, wb_ack_o, irq_n_o, busy, ben, lb, s1, u1, c1, cb;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
    logic go = 1'b0, cv = 1'b0, sv = 1'b0, mv = 1'b0, fv = 1'b0;
    logic nv = 1'b0, nb = 1'b1, af = 1'b0;
    logic [1:0] ms = 2'h0;
    logic [11:0] ns = 12'h000;
    logic [4:0] st = 5'h0D;
    logic [3:0] sw = 4'h0;
    logic [5:0] mw = 6'h00;
    logic [6:0] fw = 7'h00;
    logic [7:0] ap = 8'h00, q, c0;
    int fail_count = 0, checks = 0, cyc = 0;
    // Rows: kind, value, flags1 expected
    logic [18:0] rows [12] = '{{3'h0, 8'h02, 8'hC0}, {3'h0, 8'h01, 8'h50},
        {3'h0, 8'h00, 8'h40}, {3'h1, 8'h01, 8'h20}, {3'h1, 8'h00, 8'h00},
        {3'h2, 8'h0A, 8'h08}, {3'h2, 8'h0B, 8'h00}, {3'h3, 8'h1A, 8'h02},
        {3'h3, 8'h1B, 8'h00}, {3'h4, 8'h05, 8'h00}, {3'h4, 8'h05, 8'h00},
        {3'h4, 8'h09, 8'h01}};
    e1ev_top #(.WIN_CYC(30000)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .interwork_state_i(st[4]),
        .sig_mf_loss_state_i(st[3]), .crc_mf_loss_state_i(st[2]),
        .offline_loss_state_i(st[1]), .frame_loss_state_i(st[0]),
        .line_bit_en_i(ben), .line_bit_i(lb), .sig_mf_first_i(s1),
        .crc_submf_first_i(u1), .crc_mf_first_i(c1), .crc_cbit_i(cb),
        .sig_mf_word_vld_i(sv), .sig_mf_word_i(sw), .crc_mf_word_vld_i(mv),
        .crc_mf_word_i(mw), .fas_word_vld_i(fv), .fas_word_i(fw),
        .nfas_vld_i(nv), .nfas_bit_i(nb), .align_found_i(af),
        .align_pos_i(ap), .irq_n_o(irq_n_o));
    e1ev_line_mdl mdl_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .mf_sel_i(ms), .cval_i(cv), .nsub_i(ns), .busy_o(busy),
        .bit_en_o(ben), .bit_o(lb), .sig_mf_first_o(s1),
        .crc_submf_first_o(u1), .crc_mf_first_o(c1), .cbit_o(cb));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_irq(input logic e);
        chk("irq_n_o", {7'h00, e}, {7'h00, irq_n_o});
    endtask
    task automatic bus(input logic w, logic [7:0] i, logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {i, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
        if (n >= 20)
            fail_count++;
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic fire(input logic [2:0] k, logic [7:0] v, logic c,
        logic [11:0] n);
        int t;
        t = 0;
        case (k)
            3'h0: {go, ms, cv, ns} <= {1'b1, v[1:0], c, n};
            3'h1: {sv, sw} <= {1'b1, v[3:0]};
            3'h2: {mv, mw} <= {1'b1, v[5:0]};
            3'h3: {fv, fw} <= {1'b1, v[6:0]};
            3'h4: {af, ap} <= {1'b1, v};
            default: {nv, nb} <= {1'b1, v[0]};
        endcase
        @(posedge clk_i);
        {go, sv, mv, fv, af, nv} <= 6'h00;
        {sw, mw, fw, ap, nb} <= ~{sw, mw, fw, ap, nb};
        do @(posedge clk_i); while (busy === 1'b1 && ++t < 6000);
        repeat (3) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // Clock, timeout and sequence
    // ------------------------------------------------------------
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        if (++cyc == 40000)
        begin
            fail_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_irq(1'b1);
        bus(1'b1, 8'h54, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, e1ev_pkg::IDX_EN1 + i[7:0], 8'h00);
            chk("reset value", 8'h00, q);
        end
        bus(1'b0, e1ev_pkg::IDX_STATUS, 8'h00);
        chk("status", 8'h0D, q);
        st <= 5'h12;
        repeat (3) @(posedge clk_i);
        bus(1'b1, e1ev_pkg::IDX_FLAG0, 8'h00);
        bus(1'b0, e1ev_pkg::IDX_FLAG0, 8'h00);
        chk("change flags", 8'h1F, q);
        bus(1'b1, e1ev_pkg::IDX_FLAG0, 8'h1F);
        bus(1'b0, e1ev_pkg::IDX_FLAG0, 8'h00);
        chk("flags0 cleared", 8'h00, q);
        for (int i = 0; i < 12; i++)
        begin
            fire(rows[i][18:16], rows[i][15:8], 1'b0, 12'h001);
            bus(1'b0, e1ev_pkg::IDX_FLAG1, 8'h00);
            chk("flags1", rows[i][7:0], q);
            chk_irq(1'b1);
            bus(1'b1, e1ev_pkg::IDX_EN1, rows[i][7:0]);
            @(posedge clk_i);
            chk_irq(rows[i][7:0] == 8'h00);
            bus(1'b1, e1ev_pkg::IDX_FLAG1, rows[i][7:0]);
            @(posedge clk_i);
            chk_irq(1'b1);
            bus(1'b1, e1ev_pkg::IDX_EN1, 8'h00);
        end
        st <= 5'h0F;
        repeat (2) @(posedge clk_i);
        fire(3'h0, 8'h03, 1'b1, 12'h004);
        fire(3'h1, 8'h01, 1'b0, 12'h000);
        fire(3'h2, 8'h0A, 1'b0, 12'h000);
        fire(3'h3, 8'h1A, 1'b0, 12'h000);
        bus(1'b0, e1ev_pkg::IDX_FLAG1, 8'h00);
        chk("flags1 while lost", 8'h00, q);
        st <= 5'h12;
        repeat (2) @(posedge clk_i);
        bus(1'b1, e1ev_pkg::IDX_FLAG0, 8'hFF);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, e1ev_pkg::IDX_MODE, {3'h0, m[0], m[1], 3'h0});
            bus(1'b0, e1ev_pkg::IDX_FERR_CNT, 8'h00);
            c0 = q;
            fire(3'h3, 8'h18, 1'b0, 12'h000);
            fire(3'h5, 8'h00, 1'b0, 12'h000);
            bus(1'b0, e1ev_pkg::IDX_FERR_CNT, 8'h00);
            chk("error count", c0 + (m[1] ? 8'h01 : 8'h02) + m[0], q);
        end
        bus(1'b1, e1ev_pkg::IDX_FLAG1, 8'hFF);
        fire(3'h0, 8'h00, 1'b1, 12'h38E);
        bus(1'b0, e1ev_pkg::IDX_FLAG0, 8'h00);
        chk("excess below limit", 8'h00, q);
        bus(1'b0, e1ev_pkg::IDX_FLAG1, 8'h00);
        chk("crc4 error", 8'h44, q);
        fire(3'h0, 8'h00, 1'b1, 12'h00A);
        bus(1'b0, e1ev_pkg::IDX_FLAG0, 8'h00);
        chk("excess", 8'h20, q);
        bus(1'b1, e1ev_pkg::IDX_EN0, 8'hFF);
        @(posedge clk_i);
        chk_irq(1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_irq(1'b1);
        bus(1'b0, e1ev_pkg::IDX_FLAG0, 8'h00);
        chk("flags0 after reset", 8'h1F, q);
        complete_run();
    end
endmodule
`default_nettype wire
